/* File: verilog/brc_map.svh */
// Opcode fields, opcode values, lengths and cycle counts of the decoder.
// Assumes nothing; definitions only.
`ifndef BRC_MAP_SVH
`define BRC_MAP_SVH

// High nibble groups.
`define BRC_HI_BIT_BRANCH 4'h0
`define BRC_HI_BIT_SETCLR 4'h1
`define BRC_HI_DIRECT     4'h3
`define BRC_HI_ACC        4'h4
`define BRC_HI_INDEX      4'h5
`define BRC_HI_IX1        4'h6
`define BRC_HI_IX0        4'h7

// Low nibble operations of the read-modify-write group.
`define BRC_LO_NEGATE     4'h0
`define BRC_LO_COMPL      4'h3
`define BRC_LO_SHR        4'h4
`define BRC_LO_ROTR       4'h6
`define BRC_LO_ASHR       4'h7
`define BRC_LO_SHL        4'h8
`define BRC_LO_ROTL       4'h9
`define BRC_LO_DECR       4'ha
`define BRC_LO_INCR       4'hc
`define BRC_LO_TEST       4'hd
`define BRC_LO_ZERO       4'hf

// Whole opcodes.
`define BRC_OPC_MULTIPLY  8'h42
`define BRC_OPC_RET_INT   8'h80
`define BRC_OPC_RET_SUB   8'h81
`define BRC_OPC_TRAP      8'h83
`define BRC_OPC_STOP      8'h8e
`define BRC_OPC_WAIT      8'h8f
`define BRC_OPC_COPY_AX   8'h97
`define BRC_OPC_CARRY_OFF 8'h98
`define BRC_OPC_CARRY_ON  8'h99
`define BRC_OPC_MASK_OFF  8'h9a
`define BRC_OPC_MASK_ON   8'h9b
`define BRC_OPC_SP_RESET  8'h9c
`define BRC_OPC_NO_OP     8'h9d
`define BRC_OPC_COPY_XA   8'h9f

// Instruction lengths in bytes.
`define BRC_BYTES_ONE     2'h1
`define BRC_BYTES_TWO     2'h2
`define BRC_BYTES_THREE   2'h3

// Cycle counts.
`define BRC_CYC_INHERENT  4'h2
`define BRC_CYC_REG       4'h3
`define BRC_CYC_TEST_MEM  4'h4
`define BRC_CYC_MEM       4'h5
`define BRC_CYC_BIT       4'h5
`define BRC_CYC_TEST_IX1  4'h5
`define BRC_CYC_IX1       4'h6
`define BRC_CYC_RET_SUB   4'h6
`define BRC_CYC_RET_INT   4'h9
`define BRC_CYC_TRAP      4'ha
`define BRC_CYC_MULTIPLY  4'hb

`endif

/* File: verilog/brc_pkg.sv */
// Types shared by the opcode decoder and its timing table.
// Assumes the constants of brc_map.svh.
package brc_pkg;

  typedef enum logic [4:0] {
    OP_NONE,
    OP_BRANCH_ON_BIT_SET,
    OP_BRANCH_ON_BIT_CLEAR,
    OP_MEMORY_BIT_SET,
    OP_MEMORY_BIT_CLEAR,
    OP_INCREMENT,
    OP_DECREMENT_OP,
    OP_ZERO_OPERAND,
    OP_COMPLEMENT,
    OP_TWOS_COMPLEMENT_OP,
    OP_ROTATE_LEFT_CARRY,
    OP_ROTATE_RIGHT_CARRY,
    OP_SHIFT_LEFT_OP,
    OP_LOGICAL_RIGHT_SHIFT_OP,
    OP_ARITH_RIGHT_SHIFT_OP,
    OP_TEST_OPERAND,
    OP_MULTIPLY_OP,
    OP_COPY_ACC_TO_INDEX,
    OP_COPY_INDEX_TO_ACC,
    OP_CARRY_SET_OP,
    OP_CARRY_CLEAR_OP,
    OP_MASK_INTERRUPTS,
    OP_UNMASK_INTERRUPTS,
    OP_SOFTWARE_TRAP,
    OP_SUBROUTINE_RETURN,
    OP_INTERRUPT_RETURN,
    OP_STACK_POINTER_RESET,
    OP_NO_OPERATION,
    OP_STOP_ENTRY,
    OP_WAIT_ENTRY,
    OP_ILLEGAL
  } brc_op_t;

  typedef enum logic [2:0] {
    SRC_NONE   = 3'h0,
    SRC_ACC    = 3'h1,
    SRC_INDEX  = 3'h2,
    SRC_DIRECT = 3'h3,
    SRC_IX0    = 3'h4,
    SRC_IX1    = 3'h5
  } brc_src_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } brc_state_t;

endpackage

/* File: verilog/brc_rmw_timing.sv */
// Length and cycle table of the read-modify-write group by operand source.
// Assumes a legal read-modify-write source; SRC_NONE yields one byte, two cycles.
`timescale 1ns/10ps
`include "brc_map.svh"

module brc_rmw_timing (
  // Operand source and test flag.
  input  wire brc_pkg::brc_src_t src,
  input  wire logic              is_test,
  // Table outputs.
  output logic [1:0]             bytes,
  output logic [3:0]             cycles
);
  import brc_pkg::*;

  wire two_byte  = (src == SRC_DIRECT) || (src == SRC_IX1);
  wire reg_form  = (src == SRC_ACC) || (src == SRC_INDEX);
  wire mem_form  = (src == SRC_DIRECT) || (src == SRC_IX0);

  assign bytes  = two_byte ? `BRC_BYTES_TWO : `BRC_BYTES_ONE;

  // A test skips the write-back cycle except in register forms.
  assign cycles = reg_form             ? `BRC_CYC_REG :
                  mem_form && is_test  ? `BRC_CYC_TEST_MEM :
                  mem_form             ? `BRC_CYC_MEM :
                  (src == SRC_IX1) && is_test ? `BRC_CYC_TEST_IX1 :
                  (src == SRC_IX1)     ? `BRC_CYC_IX1 :
                  `BRC_CYC_INHERENT;

endmodule // brc_rmw_timing

/* File: verilog/brc_decoder.sv */
// Opcode decoder and cycle sequencer for the bit, read-modify-write and control groups.
// Assumes opcode bytes come from logic on clk and are held until op_ready takes them.
`timescale 1ns/10ps
`include "brc_map.svh"

module brc_decoder (
  // Clock and reset.
  input  wire  logic              clk,
  input  wire  logic              rst_n,
  // Opcode byte from program memory.
  input  wire  logic              op_valid,
  input  wire  logic [7:0]        op_byte,
  output logic                    op_ready,
  // Decoded instruction, valid for one cycle after acceptance.
  output logic                    dec_valid,
  output brc_pkg::brc_op_t        dec_op,
  output brc_pkg::brc_src_t       dec_src,
  output logic [2:0]              dec_bit,
  output logic [1:0]              dec_bytes,
  output logic [3:0]              dec_cycles,
  output logic                    dec_write_back,
  output logic                    dec_illegal,
  // Sequencing.
  output logic                    busy,
  output logic                    done
);
  import brc_pkg::*;

  brc_state_t state_q;
  logic       op_ready_q;
  logic       dec_valid_q;
  brc_op_t    dec_op_q;
  brc_src_t   dec_src_q;
  logic [2:0] dec_bit_q;
  logic [1:0] dec_bytes_q;
  logic [3:0] dec_cycles_q;
  logic       dec_write_back_q;
  logic       dec_illegal_q;
  logic       busy_q;
  logic       done_q;
  logic [3:0] cnt_q;
  logic [3:0] span_q;

  brc_op_t    rmw_op;
  brc_op_t    ctl_op;
  logic [3:0] ctl_cycles;
  logic [1:0] rmw_bytes;
  logic [3:0] rmw_cycles;

  // Field decode.
  wire [3:0] hi        = op_byte[7:4];
  wire [3:0] lo        = op_byte[3:0];
  wire [2:0] op_bit    = op_byte[3:1];
  wire       take      = op_valid && op_ready_q;
  wire       is_branch = (hi == `BRC_HI_BIT_BRANCH);
  wire       is_setclr = (hi == `BRC_HI_BIT_SETCLR);
  wire       is_mult   = (op_byte == `BRC_OPC_MULTIPLY);

  // Operand source from the high nibble.
  wire brc_src_t src_w = (hi == `BRC_HI_ACC)    ? SRC_ACC :
                         (hi == `BRC_HI_INDEX)  ? SRC_INDEX :
                         (hi == `BRC_HI_DIRECT) ? SRC_DIRECT :
                         (hi == `BRC_HI_IX0)    ? SRC_IX0 :
                         (hi == `BRC_HI_IX1)    ? SRC_IX1 : SRC_NONE;

  // Operation from the low nibble of a read-modify-write opcode.
  always_comb
  begin
    case (lo)
      `BRC_LO_ROTL:   rmw_op = OP_ROTATE_LEFT_CARRY;
      `BRC_LO_ROTR:   rmw_op = OP_ROTATE_RIGHT_CARRY;
      `BRC_LO_INCR:   rmw_op = OP_INCREMENT;
      `BRC_LO_DECR:   rmw_op = OP_DECREMENT_OP;
      `BRC_LO_ZERO:   rmw_op = OP_ZERO_OPERAND;
      `BRC_LO_COMPL:  rmw_op = OP_COMPLEMENT;
      `BRC_LO_NEGATE: rmw_op = OP_TWOS_COMPLEMENT_OP;
      `BRC_LO_SHL:    rmw_op = OP_SHIFT_LEFT_OP;
      `BRC_LO_SHR:    rmw_op = OP_LOGICAL_RIGHT_SHIFT_OP;
      `BRC_LO_ASHR:   rmw_op = OP_ARITH_RIGHT_SHIFT_OP;
      `BRC_LO_TEST:   rmw_op = OP_TEST_OPERAND;
      default:        rmw_op = OP_ILLEGAL;
    endcase
  end

  // Inherent control opcodes and their cycle counts.
  always_comb
  begin
    ctl_cycles = `BRC_CYC_INHERENT;
    case (op_byte)
      `BRC_OPC_MASK_ON:   ctl_op = OP_MASK_INTERRUPTS;
      `BRC_OPC_MASK_OFF:  ctl_op = OP_UNMASK_INTERRUPTS;
      `BRC_OPC_COPY_AX:   ctl_op = OP_COPY_ACC_TO_INDEX;
      `BRC_OPC_COPY_XA:   ctl_op = OP_COPY_INDEX_TO_ACC;
      `BRC_OPC_CARRY_ON:  ctl_op = OP_CARRY_SET_OP;
      `BRC_OPC_CARRY_OFF: ctl_op = OP_CARRY_CLEAR_OP;
      `BRC_OPC_SP_RESET:  ctl_op = OP_STACK_POINTER_RESET;
      `BRC_OPC_NO_OP:     ctl_op = OP_NO_OPERATION;
      `BRC_OPC_STOP:      ctl_op = OP_STOP_ENTRY;
      `BRC_OPC_WAIT:      ctl_op = OP_WAIT_ENTRY;
      `BRC_OPC_TRAP:
      begin
        ctl_op     = OP_SOFTWARE_TRAP;
        ctl_cycles = `BRC_CYC_TRAP;
      end
      `BRC_OPC_RET_SUB:
      begin
        ctl_op     = OP_SUBROUTINE_RETURN;
        ctl_cycles = `BRC_CYC_RET_SUB;
      end
      `BRC_OPC_RET_INT:
      begin
        ctl_op     = OP_INTERRUPT_RETURN;
        ctl_cycles = `BRC_CYC_RET_INT;
      end
      default:            ctl_op = OP_ILLEGAL;
    endcase
  end

  brc_rmw_timing u_timing (
    .src     (src_w),
    .is_test (lo == `BRC_LO_TEST),
    .bytes   (rmw_bytes),
    .cycles  (rmw_cycles)
  );

  wire rmw_legal = (src_w != SRC_NONE) && !is_mult && (rmw_op != OP_ILLEGAL);

  // Bit instructions address direct memory; bit 0 of the opcode picks set or clear.
  wire brc_op_t op_w = is_branch ? (op_byte[0] ? OP_BRANCH_ON_BIT_CLEAR : OP_BRANCH_ON_BIT_SET) :
                       is_setclr ? (op_byte[0] ? OP_MEMORY_BIT_CLEAR : OP_MEMORY_BIT_SET) :
                       is_mult   ? OP_MULTIPLY_OP :
                       rmw_legal ? rmw_op : ctl_op;

  wire [3:0] cycles_w = (is_branch || is_setclr) ? `BRC_CYC_BIT :
                        is_mult                  ? `BRC_CYC_MULTIPLY :
                        rmw_legal                ? rmw_cycles : ctl_cycles;

  wire [1:0] bytes_w  = is_branch ? `BRC_BYTES_THREE :
                        is_setclr ? `BRC_BYTES_TWO :
                        rmw_legal ? rmw_bytes : `BRC_BYTES_ONE;

  wire brc_src_t dsrc_w = (is_branch || is_setclr) ? SRC_DIRECT : rmw_legal ? src_w : SRC_NONE;
  wire       wb_w       = is_setclr || (rmw_legal && (rmw_op != OP_TEST_OPERAND));
  wire       last       = (cnt_q == 4'h1);

  // Sequencer: cycle count loaded at acceptance, done in the last cycle.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q          <= ST_IDLE;
      op_ready_q       <= 1'b1;
      dec_valid_q      <= 1'b0;
      dec_op_q         <= OP_NONE;
      dec_src_q        <= SRC_NONE;
      dec_bit_q        <= 3'h0;
      dec_bytes_q      <= 2'h0;
      dec_cycles_q     <= 4'h0;
      dec_write_back_q <= 1'b0;
      dec_illegal_q    <= 1'b0;
      busy_q           <= 1'b0;
      done_q           <= 1'b0;
      cnt_q            <= 4'h0;
    end
    else
    begin
      dec_valid_q <= 1'b0;
      done_q      <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (take)
          begin
            state_q          <= ST_EXEC;
            op_ready_q       <= 1'b0;
            busy_q           <= 1'b1;
            dec_valid_q      <= 1'b1;
            dec_op_q         <= op_w;
            dec_src_q        <= dsrc_w;
            dec_bit_q        <= op_bit;
            dec_bytes_q      <= bytes_w;
            dec_cycles_q     <= cycles_w;
            dec_write_back_q <= wb_w;
            dec_illegal_q    <= (op_w == OP_ILLEGAL);
            cnt_q            <= cycles_w - 4'h1;
          end
        end
        ST_EXEC:
        begin
          if (last)
          begin
            state_q    <= ST_IDLE;
            op_ready_q <= 1'b1;
            busy_q     <= 1'b0;
            done_q     <= 1'b1;
          end
          else
          begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign op_ready       = op_ready_q;
  assign dec_valid      = dec_valid_q;
  assign dec_op         = dec_op_q;
  assign dec_src        = dec_src_q;
  assign dec_bit        = dec_bit_q;
  assign dec_bytes      = dec_bytes_q;
  assign dec_cycles     = dec_cycles_q;
  assign dec_write_back = dec_write_back_q;
  assign dec_illegal    = dec_illegal_q;
  assign busy           = busy_q;
  assign done           = done_q;

  // Cycles elapsed since acceptance, read only by the checks below.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      span_q <= 4'h0;
    else if (take)
      span_q <= 4'h1;
    else if (busy_q)
      span_q <= span_q + 4'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_take(logic [7:0] code);
    op_valid && op_ready_q && (op_byte == code);
  endsequence

  sequence s_finish_two;
    !done_q ##1 done_q;
  endsequence

  a_branch_set_form: assert property (op_valid && op_ready_q && is_branch && !op_byte[0] |=>
    dec_op_q == OP_BRANCH_ON_BIT_SET && dec_cycles_q == 4'h5 && dec_bytes_q == 2'h3 && dec_bit_q == $past(op_bit))
    else $error("bit-set branch decoded wrongly");
  a_branch_clear_form: assert property (op_valid && op_ready_q && is_branch && op_byte[0] |=>
    dec_op_q == OP_BRANCH_ON_BIT_CLEAR && dec_bytes_q == 2'h3 ##4 done_q)
    else $error("bit-clear branch decoded wrongly");
  a_bit_write_form: assert property (op_valid && op_ready_q && is_setclr |=>
    dec_bytes_q == 2'h2 && dec_write_back_q && dec_bit_q == $past(op_bit) ##4 done_q)
    else $error("bit set or clear decoded wrongly");
  a_rotl_ix1_time: assert property (s_take(8'h69) |=> dec_op_q == OP_ROTATE_LEFT_CARRY && dec_src_q == SRC_IX1
    ##5 done_q)
    else $error("offset indexed rotate left not six cycles");
  a_rotr_len: assert property (s_take(8'h66) |=> dec_op_q == OP_ROTATE_RIGHT_CARRY && dec_bytes_q == 2'h2)
    else $error("offset indexed rotate right length wrong");
  a_test_direct: assert property (s_take(8'h3d) |=> !dec_write_back_q && dec_cycles_q == 4'h4 ##3 done_q)
    else $error("direct test timing wrong");
  a_mask_on_time: assert property (s_take(8'h9b) |=> dec_op_q == OP_MASK_INTERRUPTS ##0 s_finish_two)
    else $error("interrupt mask set not two cycles");
  a_mask_off_time: assert property (s_take(8'h9a) |=> dec_op_q == OP_UNMASK_INTERRUPTS ##0 s_finish_two)
    else $error("interrupt mask clear not two cycles");
  a_stop_time: assert property (s_take(8'h8e) |=> dec_op_q == OP_STOP_ENTRY && busy_q ##0 s_finish_two)
    else $error("stop entry not two cycles");
  a_mult_time: assert property (s_take(8'h42) |=> (!done_q)[*8] ##1 !done_q ##1 !done_q ##1 done_q)
    else $error("multiply not eleven cycles");
  a_trap_time: assert property (s_take(8'h83) |=> dec_op_q == OP_SOFTWARE_TRAP ##9 done_q)
    else $error("software trap not ten cycles");
  a_rti_time: assert property (s_take(8'h80) |=> dec_cycles_q == 4'h9 ##8 done_q)
    else $error("interrupt return not nine cycles");
  a_span_match: assert property (done_q |-> span_q == dec_cycles_q && op_ready_q)
    else $error("instruction span differs from its cycle count");

endmodule // brc_decoder

/* File: tb/brc_prog_mem.sv */
// Program memory model that hands opcode bytes to the decoder from a queue.
// Assumes the decoder samples op_valid and op_byte on the rising edge of clk.
`timescale 1ns/10ps

module brc_prog_mem (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Opcode handshake.
  input  wire logic       op_ready,
  output logic            op_valid,
  output logic [7:0]      op_byte,
  // Pulse in the cycle after a byte was taken.
  output logic            taken
);
  logic [7:0] q [$];

  initial
  begin
    op_valid = 1'b0;
    op_byte  = 8'h00;
    taken    = 1'b0;
  end

  always @(posedge clk)
    taken <= rst_n && op_valid && op_ready;

  // A released byte shows its inverse so that a stale value cannot pass for a fresh one.
  always @(negedge clk)
    if (!rst_n)
      op_valid <= 1'b0;
    else if (!op_valid || taken)
    begin
      if (q.size() > 0)
      begin
        op_byte  <= q.pop_front();
        op_valid <= 1'b1;
      end
      else
      begin
        op_valid <= 1'b0;
        op_byte  <= ~op_byte;
      end
    end
endmodule // brc_prog_mem

/* File: tb/tb_bit_rmw_control_opcode_decoder.sv */
// Self-checking bench for the opcode decoder, fed by the program memory model.
// Assumes brc_pkg is compiled first.
`timescale 1ns/10ps

module tb_bit_rmw_control_opcode_decoder;
  import brc_pkg::*;
  logic       clk, rst_n, op_valid, op_ready, taken, dec_valid, dec_write_back, dec_illegal, busy, done;
  logic [7:0] op_byte, s_n;
  logic [2:0] dec_bit;
  logic [1:0] dec_bytes;
  logic [3:0] dec_cycles;
  brc_op_t    dec_op;
  brc_src_t   dec_src;
  int         n_errors = 0, samples_checked = 0, cyc_count = 0;
  logic [3:0] rmw_lo [11] = '{4'h0, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hc, 4'hd, 4'hf};
  brc_op_t    rmw_op [11] = '{OP_TWOS_COMPLEMENT_OP, OP_COMPLEMENT, OP_LOGICAL_RIGHT_SHIFT_OP,
    OP_ROTATE_RIGHT_CARRY, OP_ARITH_RIGHT_SHIFT_OP, OP_SHIFT_LEFT_OP, OP_ROTATE_LEFT_CARRY,
    OP_DECREMENT_OP, OP_INCREMENT, OP_TEST_OPERAND, OP_ZERO_OPERAND};
  logic [3:0] src_hi [5] = '{4'h4, 4'h5, 4'h3, 4'h7, 4'h6};
  brc_src_t   src_v [5] = '{SRC_ACC, SRC_INDEX, SRC_DIRECT, SRC_IX0, SRC_IX1};
  logic [1:0] src_by [5] = '{2'h1, 2'h1, 2'h2, 2'h1, 2'h2};
  logic [3:0] src_cy [5] = '{4'h3, 4'h3, 4'h5, 4'h5, 4'h6};
  logic [3:0] src_tc [5] = '{4'h3, 4'h3, 4'h4, 4'h4, 4'h5};
  logic [7:0] ctl_b [14] = '{8'h97, 8'h9f, 8'h99, 8'h98, 8'h9b, 8'h9a, 8'h9c, 8'h9d, 8'h8e, 8'h8f,
    8'h42, 8'h83, 8'h81, 8'h80};
  brc_op_t    ctl_op [14] = '{OP_COPY_ACC_TO_INDEX, OP_COPY_INDEX_TO_ACC, OP_CARRY_SET_OP, OP_CARRY_CLEAR_OP,
    OP_MASK_INTERRUPTS, OP_UNMASK_INTERRUPTS, OP_STACK_POINTER_RESET, OP_NO_OPERATION, OP_STOP_ENTRY,
    OP_WAIT_ENTRY, OP_MULTIPLY_OP, OP_SOFTWARE_TRAP, OP_SUBROUTINE_RETURN, OP_INTERRUPT_RETURN};
  logic [3:0] ctl_cy [14] = '{4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'hb, 4'ha, 4'h6, 4'h9};

  brc_prog_mem mem (.clk(clk), .rst_n(rst_n), .op_ready(op_ready), .op_valid(op_valid), .op_byte(op_byte),
    .taken(taken));
  brc_decoder dut (.clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op_byte(op_byte), .op_ready(op_ready),
    .dec_valid(dec_valid), .dec_op(dec_op), .dec_src(dec_src), .dec_bit(dec_bit), .dec_bytes(dec_bytes),
    .dec_cycles(dec_cycles), .dec_write_back(dec_write_back), .dec_illegal(dec_illegal), .busy(busy),
    .done(done));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc_count++;
    if (cyc_count == 20000)
    begin
      n_errors++;
      conclude();
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Sends one opcode, checks the decode pulse and counts cycles up to done.
  task automatic run_op(input logic [7:0] b, input brc_op_t eop, input brc_src_t esrc, input logic [1:0] eby,
      input logic [3:0] ecy, input logic ewb, input logic eill);
    int k;
    @(posedge clk);
    mem.q.push_back(b);
    k = 0;
    do begin @(negedge clk); k++; end while (taken !== 1'b1 && k < 20);
    check("dec_valid", dec_valid, 8'h01);
    check("busy", busy, 8'h01);
    check("dec_op", dec_op, eop);
    check("dec_src", dec_src, esrc);
    check("dec_bytes", dec_bytes, eby);
    check("dec_cycles", dec_cycles, ecy);
    check("dec_write_back", dec_write_back, ewb);
    check("dec_illegal", dec_illegal, eill);
    s_n = 8'h01;
    while (done !== 1'b1 && s_n < 8'h14)
    begin
      @(negedge clk);
      s_n++;
    end
    check("cycles", s_n, ecy);
    check("op_ready", op_ready, 8'h01);
    check("busy_end", busy, 8'h00);
  endtask

  task automatic bit_ops;
    logic [7:0] b;
    for (int n = 0; n < 8; n++)
      for (int k = 0; k < 4; k++)
      begin
        b = {3'h0, k[1], n[2:0], k[0]};
        run_op(b, k == 0 ? OP_BRANCH_ON_BIT_SET : k == 1 ? OP_BRANCH_ON_BIT_CLEAR :
          k == 2 ? OP_MEMORY_BIT_SET : OP_MEMORY_BIT_CLEAR, SRC_DIRECT, k[1] ? 2'h2 : 2'h3, 4'h5, k[1], 1'b0);
        check("dec_bit", dec_bit, n[2:0]);
      end
  endtask

  task automatic rmw_ops;
    logic t;
    for (int s = 0; s < 5; s++)
      for (int l = 0; l < 11; l++)
      begin
        t = (rmw_lo[l] == 4'hd);
        run_op({src_hi[s], rmw_lo[l]}, rmw_op[l], src_v[s], src_by[s], t ? src_tc[s] : src_cy[s], !t, 1'b0);
      end
  endtask

  task automatic ctl_ops;
    for (int i = 0; i < 14; i++)
      run_op(ctl_b[i], ctl_op[i], SRC_NONE, 2'h1, ctl_cy[i], 1'b0, 1'b0);
    run_op(8'h41, OP_ILLEGAL, SRC_NONE, 2'h1, 4'h2, 1'b0, 1'b1);
    run_op(8'h7b, OP_ILLEGAL, SRC_NONE, 2'h1, 4'h2, 1'b0, 1'b1);
  endtask

  // The multiply byte waits, refused, while the mask opcode runs, and is taken on the edge after done rises.
  task automatic back_to_back;
    @(posedge clk);
    mem.q.push_back(8'h9b);
    run_op(8'h42, OP_MASK_INTERRUPTS, SRC_NONE, 2'h1, 4'h2, 1'b0, 1'b0);
    @(negedge clk);
    check("second_taken", taken, 8'h01);
    check("second_op", dec_op, OP_MULTIPLY_OP);
    s_n = 8'h01;
    while (done !== 1'b1 && s_n < 8'h14)
    begin
      @(negedge clk);
      s_n++;
    end
    check("mul_cycles", s_n, 8'h0b);
  endtask

  task automatic reset_mid;
    @(posedge clk);
    mem.q.push_back(8'h83);
    repeat (4) @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    check("rst_ready", op_ready, 8'h01);
    check("rst_busy", {busy, done, dec_valid}, 8'h00);
    check("rst_op", dec_op, OP_NONE);
    rst_n = 1'b1;
    run_op(8'h83, OP_SOFTWARE_TRAP, SRC_NONE, 2'h1, 4'ha, 1'b0, 1'b0);
  endtask

  initial
  begin
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    bit_ops();
    rmw_ops();
    ctl_ops();
    back_to_back();
    reset_mid();
    conclude();
  end
endmodule // tb_bit_rmw_control_opcode_decoder
